// ===== src/lpm_pkg.sv
// What this block does
// - mode pin low at reset release: background
// - background command, halt instruction, breakpoint: background
// - background holds cpu suspended, no fetch
// - some commands need background; others allowed outside wait/stop
// - wait gates cpu clock, clears interrupt mask
// - interrupt during wait restores cpu, stacking
// - wait/stop: only background and status commands
// - background command in wait enters background
// - stop without enable forces illegal opcode reset
// - enabled stop halts internal clocks, debug clock too unless debug enable
// - deep stop needs select, enable, no detector
// - detector in stop forces retention, regulator on
// - deep stop latches pins until acknowledge
// - deep stop powers off all but ram
// - deep exit: reset, low irq pin, timer
// - deep wake behaves like power-on reset
// - wake flag set until acknowledge written
// - opened latches follow port or peripheral
// - retention keeps state; wake by source vector
// - debug enable keeps debug clock, retention only
// - background command in stop with debug enable
// - every stop halts peripheral clocks
package lpm_pkg;
	// ===========================================================
	// register map (byte addresses)
	localparam logic [7:0] LPM_CTRL_OFS = 8'h00;
	localparam logic [7:0] LPM_STAT_OFS = 8'h04;
	// control field positions
	localparam int LPM_STOP_ENABLE_BIT_BIT = 0;
	localparam int LPM_DEEP_POWERDOWN_SELECT_BIT = 1;
	localparam int LPM_DETECTOR_ENABLE_BIT = 2;
	localparam int LPM_DETECTOR_IN_STOP_ENABLE_BIT = 3;
	localparam int LPM_DEBUG_ENTRY_ENABLE_BIT = 4;
	localparam int LPM_ACK_BIT = 5;
	// status field positions
	localparam int LPM_FLAG_BIT = 3;
	localparam int LPM_LATCH_BIT = 4;
	// reset values
	localparam logic [4:0] LPM_CTRL_RST = 5'h00;
	localparam logic [1:0] LPM_RESP_OKAY = 2'h0;
	localparam logic [1:0] LPM_RESP_SLVERR = 2'h2;
	// debug command classes
	typedef enum logic [2:0] {
		LPM_CMD_MEM,
		LPM_CMD_MEMSTAT,
		LPM_CMD_DBGREG,
		LPM_CMD_BACKGROUND,
		LPM_CMD_CPUREG,
		LPM_CMD_TRACE,
		LPM_CMD_GO
	} lpm_cmd_t;
	// operating modes
	typedef enum logic [2:0] {
		LPM_RUN,
		LPM_BKGD,
		LPM_WAIT,
		LPM_STOP3,
		LPM_STOP2
	} lpm_mode_t;
endpackage

// ===== src/lpm_cmd_filter.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// debug command admission by mode
module lpm_cmd_filter
	import lpm_pkg::*;
(
	// command in
	input wire lpm_pkg::lpm_cmd_t cmd,
	input wire lpm_pkg::lpm_mode_t mode,
	// verdict
	output logic accept,
	output logic stat_err
);
	always_comb
	begin
		accept = 1'b0;
		stat_err = 1'b0;
		unique case (mode)
			LPM_WAIT, LPM_STOP3, LPM_STOP2:
			begin
				// low power: only background and status commands
				accept = (cmd == LPM_CMD_BACKGROUND) || (cmd == LPM_CMD_MEMSTAT);
				stat_err = (cmd == LPM_CMD_MEMSTAT);
			end
			LPM_RUN:
				// non-intrusive set only
				accept = (cmd == LPM_CMD_MEM) || (cmd == LPM_CMD_MEMSTAT) ||
					(cmd == LPM_CMD_DBGREG) || (cmd == LPM_CMD_BACKGROUND);
			LPM_BKGD:
				// everything is available in background
				accept = 1'b1;
			default:
				accept = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ===== src/lpm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// low power mode controller
module lpm_ctrl
	import lpm_pkg::*;
#(
	parameter int PIN_W = 6 // number of latched i/o pins
)
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// axi4-lite write
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// axi4-lite read
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// mode strap level, then cpu events, one-cycle pulses
	input wire logic debug_mode_select_pin,
	input wire logic halt_to_debug_instruction,
	input wire logic breakpoint_hit,
	input wire logic wait_instruction,
	input wire logic stop_instruction,
	input wire logic irq_request,
	// wake sources
	input wire logic irq_pin_n,
	input wire logic periodic_wakeup_timer,
	input wire logic other_wake_irq,
	// debug command strobe
	input wire logic cmd_valid,
	input wire lpm_pkg::lpm_cmd_t cmd,
	// pin path
	input wire logic [PIN_W-1:0] pin_live,
	// outputs
	output logic cpu_clk_en,
	output logic cpu_suspend,
	output logic clear_imask,
	output logic take_irq_vector,
	output logic illegal_op_reset,
	output logic por_reset,
	output logic periph_clk_en,
	output logic debug_clk_en,
	output logic regulator_full,
	output logic powerdown_domain_off,
	output logic cmd_accept,
	output logic cmd_stat_err,
	output lpm_pkg::lpm_mode_t cur_mode,
	output logic [PIN_W-1:0] pin_out
);
	// ===========================================================
	// state
	lpm_mode_t mode_r; // current mode
	logic [4:0] ctrl_r; // software control bits
	logic flag_r; // powerdown wake flag
	logic latch_r; // pin latches closed
	logic [PIN_W-1:0] held_r; // latched pin levels
	logic strap_pend_r; // sample mode pin after reset release
	logic accept_w;
	logic err_w;
	logic ack_w; // acknowledge written this cycle
	logic stop_enable_bit;
	logic deep_powerdown_select;
	logic lvd_stop;
	logic debug_entry_enable;
	logic bgcmd; // accepted background command
	logic deep_wake; // deep stop exit by low irq pin or timer
	logic aw_hold_r; // write address taken
	logic w_hold_r; // write data taken
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	assign stop_enable_bit = ctrl_r[LPM_STOP_ENABLE_BIT_BIT];
	assign deep_powerdown_select = ctrl_r[LPM_DEEP_POWERDOWN_SELECT_BIT];
	assign lvd_stop = ctrl_r[LPM_DETECTOR_ENABLE_BIT] & ctrl_r[LPM_DETECTOR_IN_STOP_ENABLE_BIT];
	assign debug_entry_enable = ctrl_r[LPM_DEBUG_ENTRY_ENABLE_BIT];
	assign bgcmd = cmd_valid && accept_w && (cmd == LPM_CMD_BACKGROUND);
	// reset pin is resetn itself; irq pin active low in deep stop
	assign deep_wake = !irq_pin_n || periodic_wakeup_timer;
	// ===========================================================
	// command admission
	lpm_cmd_filter u_filter (
		.cmd(cmd),
		.mode(mode_r),
		.accept(accept_w),
		.stat_err(err_w)
	);
	// ===========================================================
	// mode sequencer
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_r <= LPM_RUN;
			strap_pend_r <= 1'b1;
		end
		else
		begin
			strap_pend_r <= 1'b0;
			unique case (mode_r)
				LPM_RUN:
				begin
					// strap caught at first edge after release
					if (strap_pend_r && !debug_mode_select_pin)
						mode_r <= LPM_BKGD;
					else if (bgcmd || halt_to_debug_instruction || breakpoint_hit)
						mode_r <= LPM_BKGD;
					else if (wait_instruction)
						mode_r <= LPM_WAIT;
					else if (stop_instruction && stop_enable_bit)
					begin
						// deep only with select, enable, no detector, no debug
						if (deep_powerdown_select && !lvd_stop && !debug_entry_enable)
							mode_r <= LPM_STOP2;
						else
							mode_r <= LPM_STOP3;
					end
				end
				LPM_BKGD:
				begin
					// leave only on go
					if (cmd_valid && cmd == LPM_CMD_GO)
						mode_r <= LPM_RUN;
				end
				LPM_WAIT:
				begin
					if (bgcmd)
						mode_r <= LPM_BKGD;
					else if (irq_request)
						mode_r <= LPM_RUN;
				end
				LPM_STOP3:
				begin
					if (bgcmd && debug_entry_enable)
						mode_r <= LPM_BKGD;
					else if (irq_request || other_wake_irq || periodic_wakeup_timer || !irq_pin_n)
						mode_r <= LPM_RUN;
				end
				LPM_STOP2:
				begin
					// wake like power on, always to run
					if (deep_wake)
						mode_r <= LPM_RUN;
				end
				default:
					mode_r <= LPM_RUN;
			endcase
		end
	end
	// ===========================================================
	// derived controls, registered so outputs come from flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cpu_clk_en <= 1'b1;
			cpu_suspend <= 1'b0;
			periph_clk_en <= 1'b1;
			debug_clk_en <= 1'b1;
			regulator_full <= 1'b1;
			powerdown_domain_off <= 1'b0;
			cur_mode <= LPM_RUN;
		end
		else
		begin
			// cpu clock off in wait and stop
			cpu_clk_en <= (mode_r == LPM_RUN) || (mode_r == LPM_BKGD);
			cpu_suspend <= (mode_r == LPM_BKGD);
			// peripherals halted in every stop
			periph_clk_en <= (mode_r != LPM_STOP2) && (mode_r != LPM_STOP3);
			// debug logic keeps its clock in stop only with enable
			debug_clk_en <= !((mode_r == LPM_STOP2) || (mode_r == LPM_STOP3 && !debug_entry_enable));
			// regulator standby only when nothing needs it
			regulator_full <= !((mode_r == LPM_STOP2) || (mode_r == LPM_STOP3 && !debug_entry_enable && !lvd_stop));
			powerdown_domain_off <= (mode_r == LPM_STOP2);
			cur_mode <= mode_r;
		end
	end
	// ===========================================================
	// event pulses to the core
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			clear_imask <= 1'b0;
			take_irq_vector <= 1'b0;
			illegal_op_reset <= 1'b0;
			por_reset <= 1'b0;
		end
		else
		begin
			// mask cleared on wait entry
			clear_imask <= (mode_r == LPM_RUN) && wait_instruction && !bgcmd &&
				!halt_to_debug_instruction && !breakpoint_hit && !strap_pend_r;
			// interrupt wake takes its vector, stacking first
			take_irq_vector <= ((mode_r == LPM_WAIT) && irq_request && !bgcmd) ||
				((mode_r == LPM_STOP3) && !(bgcmd && debug_entry_enable) &&
				(irq_request || other_wake_irq || periodic_wakeup_timer || !irq_pin_n));
			// stop with enable clear
			illegal_op_reset <= (mode_r == LPM_RUN) && stop_instruction && !stop_enable_bit &&
				!wait_instruction && !bgcmd && !halt_to_debug_instruction && !breakpoint_hit && !strap_pend_r;
			// deep wake resets everything but pin latches and wake flag
			por_reset <= (mode_r == LPM_STOP2) && deep_wake;
		end
	end
	// ===========================================================
	// debug command verdict
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmd_accept <= 1'b0;
			cmd_stat_err <= 1'b0;
		end
		else
		begin
			cmd_accept <= cmd_valid && accept_w;
			cmd_stat_err <= cmd_valid && err_w;
		end
	end
	// ===========================================================
	// pin latches and wake flag
	assign ack_w = aw_hold_r && w_hold_r && !s_bvalid && awaddr_r == LPM_CTRL_OFS &&
		wstrb_r[0] && wdata_r[LPM_ACK_BIT];
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			latch_r <= 1'b0;
			flag_r <= 1'b0;
			held_r <= '0;
		end
		else
		begin
			// capture pins on deep stop entry
			if (mode_r == LPM_RUN && stop_instruction && stop_enable_bit && deep_powerdown_select && !lvd_stop && !debug_entry_enable &&
				!wait_instruction && !bgcmd && !halt_to_debug_instruction && !breakpoint_hit &&
				!strap_pend_r)
			begin
				latch_r <= 1'b1;
				held_r <= pin_live;
			end
			else if (ack_w)
				latch_r <= 1'b0;
			// set wins over acknowledge
			if (mode_r == LPM_STOP2 && deep_wake)
				flag_r <= 1'b1;
			else if (ack_w)
				flag_r <= 1'b0;
		end
	end
	// opened latches pass port or peripheral value
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pin_out <= '0;
		else
			pin_out <= latch_r ? held_r : pin_live;
	end
	// ===========================================================
	// axi4-lite write path
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= LPM_RESP_OKAY;
			ctrl_r <= LPM_CTRL_RST;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (aw_hold_r && w_hold_r && !s_bvalid)
			begin
				s_bvalid <= 1'b1;
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				if (awaddr_r == LPM_CTRL_OFS)
				begin
					s_bresp <= LPM_RESP_OKAY;
					if (wstrb_r[0])
						ctrl_r <= wdata_r[4:0];
				end
				else if (awaddr_r == LPM_STAT_OFS)
					s_bresp <= LPM_RESP_OKAY; // status ignores writes
				else
					s_bresp <= LPM_RESP_SLVERR;
			end
			else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end
	assign s_awready = !aw_hold_r && !s_bvalid;
	assign s_wready = !w_hold_r && !s_bvalid;
	// ===========================================================
	// axi4-lite read path
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= LPM_RESP_OKAY;
		end
		else if (s_arvalid && s_arready)
		begin
			s_rvalid <= 1'b1;
			s_rresp <= LPM_RESP_OKAY;
			if (s_araddr == LPM_CTRL_OFS)
				s_rdata <= {27'h0000000, ctrl_r};
			else if (s_araddr == LPM_STAT_OFS)
				s_rdata <= {27'h0000000, latch_r, flag_r, mode_r};
			else
			begin
				s_rdata <= 32'h0000_0000;
				s_rresp <= LPM_RESP_SLVERR;
			end
		end
		else if (s_rvalid && s_rready)
			s_rvalid <= 1'b0;
	end
	assign s_arready = !s_rvalid;
	// ===========================================================
	// checks
	property p_wait_gate;
		@(posedge clk) disable iff (!resetn)
		(mode_r == LPM_WAIT) |=> !cpu_clk_en;
	endproperty
	a_wait_gate: assert property (p_wait_gate) else $error("cpu clock running in wait");
	property p_no_stop;
		@(posedge clk) disable iff (!resetn)
		(mode_r == LPM_RUN && stop_instruction && !stop_enable_bit) |=> (mode_r != LPM_STOP2 && mode_r != LPM_STOP3);
	endproperty
	a_no_stop: assert property (p_no_stop) else $error("stop entered with enable clear");
	property p_deep_sel;
		@(posedge clk) disable iff (!resetn)
		(mode_r == LPM_STOP2) |-> (deep_powerdown_select && !lvd_stop && !debug_entry_enable);
	endproperty
	a_deep_sel: assert property (p_deep_sel) else $error("deep stop selected wrongly");
	property p_periph;
		@(posedge clk) disable iff (!resetn)
		(mode_r == LPM_STOP3 || mode_r == LPM_STOP2) |=> !periph_clk_en;
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral clock on in stop");
	property p_flag;
		@(posedge clk) disable iff (!resetn)
		(mode_r == LPM_STOP2 && deep_wake) |=> flag_r;
	endproperty
	a_flag: assert property (p_flag) else $error("wake flag not set");
	property p_latch_hold;
		@(posedge clk) disable iff (!resetn)
		(latch_r && !ack_w) |=> (latch_r && $stable(held_r));
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("pin latch lost");
	property p_filter;
		@(posedge clk) disable iff (!resetn)
		(cmd_valid && mode_r == LPM_WAIT && cmd == LPM_CMD_MEM) |=> !cmd_accept;
	endproperty
	a_filter: assert property (p_filter) else $error("memory command accepted in wait");
	property p_bg_wait;
		@(posedge clk) disable iff (!resetn)
		(mode_r == LPM_WAIT && bgcmd) |=> (mode_r == LPM_BKGD) ##1 cpu_suspend;
	endproperty
	a_bg_wait: assert property (p_bg_wait) else $error("background from wait failed");
endmodule
`default_nettype wire

// ===== tb/lpm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// cpu core, wake sources and debugger stand-in
module lpm_far_model
	import lpm_pkg::*;
(
	// clock
	input wire logic clk,
	// core and wake events
	output logic debug_mode_select_pin,
	output logic [6:0] ev,
	output logic irq_pin_n,
	// debugger command strobe
	output logic cmd_valid,
	output lpm_pkg::lpm_cmd_t cmd
);
	// idle levels from time zero
	initial
	begin
		debug_mode_select_pin = 1'b1;
		ev = 7'h00;
		irq_pin_n = 1'b1; // wake pin idles high, low wakes
		cmd_valid = 1'b0;
		cmd = LPM_CMD_MEM;
	end
	// strap level, only ever changed while reset is held
	task strap(input logic v);
		debug_mode_select_pin <= v;
	endtask
	// one-cycle event; index 7 is a low pulse on the wake pin
	task fire(input int i);
		@(posedge clk);
		if (i == 7) irq_pin_n <= 1'b0;
		else ev[i] <= 1'b1;
		@(posedge clk);
		irq_pin_n <= 1'b1;
		ev <= 7'h00;
	endtask
	// one command; the code is scrambled afterwards so a stale value cannot pass
	task send(input lpm_cmd_t c);
		@(posedge clk);
		cmd <= c;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd <= lpm_cmd_t'(~c);
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// self-checking bench: drivers note expectations, monitors compare
module testbench;
	import lpm_pkg::*;
	logic clk;
	logic resetn;
	logic [7:0] s_awaddr;
	logic [7:0] s_araddr;
	logic [31:0] s_wdata;
	logic [31:0] s_rdata;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	logic [1:0] s_bresp, s_rresp;
	wire strap, irq_pin_n, cmd_valid;
	wire [6:0] ev;
	lpm_cmd_t cmd;
	lpm_mode_t cur_mode;
	logic [5:0] pin_live, pin_out, pins_e;
	wire [5:0] pv; // clear_imask, irq vector, illegal, por, accept, stat_err
	wire [5:0] lv; // cpu clk, suspend, periph clk, debug clk, regulator, domain off
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	logic look;
	logic [5:0] pq[$];
	logic [33:0] rq[$];
	logic [29:0] sq[$];
	logic [1:0] bq[$];
	logic [29:0] sn; // state note being checked
	lpm_far_model fm (.clk(clk), .debug_mode_select_pin(strap), .ev(ev), .irq_pin_n(irq_pin_n),
		.cmd_valid(cmd_valid), .cmd(cmd));
	lpm_ctrl #(.PIN_W(6)) uut (.clk(clk), .resetn(resetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .debug_mode_select_pin(strap),
		.halt_to_debug_instruction(ev[0]), .breakpoint_hit(ev[1]), .wait_instruction(ev[2]),
		.stop_instruction(ev[3]), .irq_request(ev[4]), .irq_pin_n(irq_pin_n),
		.periodic_wakeup_timer(ev[5]), .other_wake_irq(ev[6]), .cmd_valid(cmd_valid), .cmd(cmd),
		.pin_live(pin_live), .cpu_clk_en(lv[5]), .cpu_suspend(lv[4]), .clear_imask(pv[5]),
		.take_irq_vector(pv[4]), .illegal_op_reset(pv[3]), .por_reset(pv[2]), .periph_clk_en(lv[3]),
		.debug_clk_en(lv[2]), .regulator_full(lv[1]), .powerdown_domain_off(lv[0]),
		.cmd_accept(pv[1]), .cmd_stat_err(pv[0]), .cur_mode(cur_mode), .pin_out(pin_out));
	// ===========================================================
	// comparison and verdict
	task cmp(input string what, input logic [33:0] e, input logic [33:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	// notes left over mean an expected result never showed up
	task end_of_test();
		error_cnt += pq.size() + rq.size() + sq.size() + bq.size();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ===========================================================
	// monitors: every pulse, read beat and state probe pops one note
	always @(posedge clk)
		if (resetn === 1'b1 && pv !== 6'h00)
			cmp("pulse", {28'h0, (pq.size() > 0) ? pq.pop_front() : 6'h00}, {28'h0, pv});
	always @(posedge clk)
		if (s_rvalid === 1'b1 && s_rready === 1'b1 && rq.size() > 0)
			cmp("read", rq.pop_front(), {s_rresp, s_rdata});
	always @(posedge clk)
		if (s_bvalid === 1'b1 && s_bready === 1'b1 && bq.size() > 0)
			cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, s_bresp});
	// note popped first so both sides use the same entry
	always @(negedge clk)
		if (look === 1'b1 && sq.size() > 0)
		begin
			sn = sq.pop_front();
			cmp("state", {19'h0, sn[29:15] & sn[14:0]}, {19'h0, {cur_mode, lv, pin_out} & sn[14:0]});
		end
	// clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	// ===========================================================
	// drivers
	task do_reset(input logic s);
		fm.strap(s);
		resetn <= 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	// probe levels after the mode has settled; k masks unspecified levels
	task exp_s(input lpm_mode_t m, input logic [5:0] l, input logic [5:0] k);
		repeat (3) @(posedge clk);
		sq.push_back({m, l, pins_e, 3'h7, k, 6'h3f});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask
	task fire(input int i, input logic [5:0] p);
		if (p != 6'h00) pq.push_back(p);
		fm.fire(i);
	endtask
	task cm(input lpm_cmd_t c, input logic [5:0] p);
		if (p != 6'h00) pq.push_back(p);
		fm.send(c);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		// only the two mapped words answer okay
		bq.push_back((a == LPM_CTRL_OFS || a == LPM_STAT_OFS) ? LPM_RESP_OKAY : LPM_RESP_SLVERR);
		@(posedge clk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_awready === 1'b1) s_awvalid <= 1'b0;
			if (s_wready === 1'b1) s_wvalid <= 1'b0;
		end
		while (s_bvalid !== 1'b1);
		s_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		@(posedge clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(posedge clk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		do @(posedge clk); while (s_rvalid !== 1'b1);
		s_rready <= 1'b0;
	endtask
	// ===========================================================
	// main sequence
	initial
	begin
		void'($urandom(32'h6f25));
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, look} = 6'h00;
		s_awaddr = 8'h00;
		s_araddr = 8'h00;
		s_wdata = 32'h0;
		resetn = 1'b0;
		pin_live = 6'($urandom());
		pins_e = pin_live;
		do_reset(1'b0);
		exp_s(LPM_BKGD, 6'h1e, 6'h1f);
		cm(LPM_CMD_GO, 6'h02);
		exp_s(LPM_RUN, 6'h2e, 6'h3f);
		do_reset(1'b1);
		exp_s(LPM_RUN, 6'h2e, 6'h3f);
		rd(LPM_STAT_OFS, {LPM_RESP_OKAY, 32'h0});
		$display("test strap done");
		for (int i = 0; i < 3; i++)
		begin
			if (i == 0) cm(LPM_CMD_BACKGROUND, 6'h02);
			else fire(i - 1, 6'h00);
			exp_s(LPM_BKGD, 6'h1e, 6'h1f);
			cm(LPM_CMD_CPUREG, 6'h02);
			cm(LPM_CMD_GO, 6'h02);
			exp_s(LPM_RUN, 6'h2e, 6'h3f);
		end
		for (int c = 0; c < 7; c++)
			if (c != 3) cm(lpm_cmd_t'(c), (c < 3) ? 6'h02 : 6'h00);
		exp_s(LPM_RUN, 6'h2e, 6'h3f);
		$display("test background done");
		fire(2, 6'h20);
		exp_s(LPM_WAIT, 6'h0e, 6'h2f);
		for (int c = 0; c < 7; c++)
			if (c != 3) cm(lpm_cmd_t'(c), (c == 1) ? 6'h03 : 6'h00);
		exp_s(LPM_WAIT, 6'h0e, 6'h2f);
		fire(4, 6'h10);
		exp_s(LPM_RUN, 6'h2e, 6'h3f);
		fire(2, 6'h20);
		cm(LPM_CMD_BACKGROUND, 6'h02);
		exp_s(LPM_BKGD, 6'h1e, 6'h1f);
		cm(LPM_CMD_GO, 6'h02);
		$display("test wait done");
		wr(LPM_CTRL_OFS, 32'h0);
		fire(3, 6'h08);
		exp_s(LPM_RUN, 6'h2e, 6'h3f);
		wr(LPM_CTRL_OFS, 32'h3f);
		rd(LPM_CTRL_OFS, {LPM_RESP_OKAY, 32'h1f});
		wr(LPM_CTRL_OFS, 32'h03);
		fire(3, 6'h00);
		exp_s(LPM_STOP2, 6'h01, 6'h2f);
		pin_live <= pin_live ^ 6'($urandom() | 1);
		exp_s(LPM_STOP2, 6'h01, 6'h2f);
		fire(7, 6'h04);
		exp_s(LPM_RUN, 6'h2e, 6'h3f);
		rd(LPM_STAT_OFS, {LPM_RESP_OKAY, 32'h18});
		wr(LPM_CTRL_OFS, 32'h20);
		pins_e = pin_live;
		exp_s(LPM_RUN, 6'h2e, 6'h3f);
		rd(LPM_STAT_OFS, {LPM_RESP_OKAY, 32'h0});
		$display("test deep stop done");
		wr(LPM_CTRL_OFS, 32'h0f);
		fire(3, 6'h00);
		exp_s(LPM_STOP3, 6'h02, 6'h2f);
		rd(LPM_STAT_OFS, {LPM_RESP_OKAY, 32'h3});
		fire(6, 6'h10);
		exp_s(LPM_RUN, 6'h2e, 6'h3f);
		wr(LPM_CTRL_OFS, 32'h13);
		fire(3, 6'h00);
		exp_s(LPM_STOP3, 6'h06, 6'h2f);
		cm(LPM_CMD_MEM, 6'h00);
		cm(LPM_CMD_MEMSTAT, 6'h03);
		cm(LPM_CMD_BACKGROUND, 6'h02);
		exp_s(LPM_BKGD, 6'h1e, 6'h1f);
		cm(LPM_CMD_CPUREG, 6'h02);
		cm(LPM_CMD_GO, 6'h02);
		rd(8'h08, {LPM_RESP_SLVERR, 32'h0});
		wr(8'h08, 32'h0);
		wr(LPM_STAT_OFS, 32'h1f);
		rd(LPM_STAT_OFS, {LPM_RESP_OKAY, 32'h0});
		repeat (4) @(posedge clk);
		$display("test retention stop done");
		end_of_test();
	end
endmodule
`default_nettype wire
